//--- rtl/hle_error_log.sv
// Function
// (R01) The first error goes to the first log; later errors go to next log.
// (R02) No new first-log bit is set until software clears the held one.
// (R03) Errors arriving in the same cycle as the first are all latched.
// (R04) Log bits survive reset; writing one clears, writing zero leaves alone.
// (R05) Bit 6: own hub-link cycle ended by target abort, non-fatal.
// (R06) Bit 5: enhanced configuration access aimed at legacy link, fatal.
// (R07) Bit 4: data phase parity error on the hub link, non-fatal.
// (R08) Bit 3: out-of-range address, including above 4G, fatal.
// (R09) Bit 2: internal parity error in the link bridge, non-fatal.
// (R10) Bit 1: illegal access arriving from the hub link, fatal.
// (R11) Bit 0: address or command parity error on the link, fatal.
// (R12) Next log holds all later errors, same bits, several at once.
// (R13) A masked error is neither logged anywhere nor reported.
// (R14) Mask bits match log bits, one masks, and survive reset.
// (R15) A set log bit with its enable sends a control interrupt message.
// (R16) Software enables at most one message type per error.
// (R17) Global next log matches global first layout, 32 bits, sticky, zero.
// (R18) Fatal errors set global bit 25, non-fatal ones global bit 11.
// (R19) Global first log keeps first fatal and non-fatal; later go next.
// (R20) Each message is a one-cycle request when a new log bit sets.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "hle_defs.svh"

module hle_error_log
	import hle_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`HLE_ERR_MSB:0] hub_link_err_event,
	output logic control_interrupt_message,
	output logic management_interrupt_message
);

	// ==========================================================
	// Write-one-to-clear helper, shared by the first and next unit logs.
	function automatic hle_err_t w1c(input hle_err_t cur,
		input hle_err_t ones, input logic hit);
		w1c = hit ? (cur & ~ones) : cur;
	endfunction

	// ==========================================================
	// Storage. The logs and the mask sit on the power-on reset only,
	// so a platform reset leaves the error record readable afterwards.
	hle_err_t hub_link_first_error_log;
	hle_err_t hub_link_next_error_log;
	hle_err_t hub_link_error_suppress;
	hle_err_t hub_link_ctrl_irq_enable;
	hle_err_t hub_link_mgmt_irq_enable;
	hle_glb_t global_earliest_error_log;
	hle_glb_t global_later_error_log;

	// ==========================================================
	// Bus decode.
	logic [9:0] word_idx;
	logic apb_access;
	logic apb_done;
	logic wr_done;
	logic hit_first;
	logic hit_next;
	logic hit_supp;
	logic hit_ctrl;
	logic hit_mgmt;
	logic hit_gfirst;
	logic hit_gnext;
	logic hit_any;
	hle_err_t wr_err;
	hle_glb_t wr_glb;

	assign word_idx = paddr[11:2];
	assign apb_access = psel & penable;
	assign apb_done = apb_access & pready;
	assign wr_done = apb_done & pwrite;
	assign hit_first = (word_idx == `HLE_IDX_FIRST);
	assign hit_next = (word_idx == `HLE_IDX_NEXT);
	assign hit_supp = (word_idx == `HLE_IDX_SUPPRESS);
	assign hit_ctrl = (word_idx == `HLE_IDX_CTRL_EN);
	assign hit_mgmt = (word_idx == `HLE_IDX_MGMT_EN);
	assign hit_gfirst = (word_idx == `HLE_IDX_GLB_FIRST);
	assign hit_gnext = (word_idx == `HLE_IDX_GLB_NEXT);
	assign hit_any = hit_first | hit_next | hit_supp | hit_ctrl |
		hit_mgmt | hit_gfirst | hit_gnext;
	assign wr_err = pwdata[`HLE_ERR_MSB:0];
	assign wr_glb = {pwdata[`HLE_GLB_FATAL_BIT],
		pwdata[`HLE_GLB_NONFATAL_BIT]};

	// ==========================================================
	// Error classification.
	hle_err_t err_fatal;
	assign err_fatal[`HLE_BIT_TGT_ABORT] = 1'b0; // [R05]
	assign err_fatal[`HLE_BIT_ENH_CFG] = 1'b1; // [R06]
	assign err_fatal[`HLE_BIT_DATA_PAR] = 1'b0; // [R07]
	assign err_fatal[`HLE_BIT_RANGE] = 1'b1; // [R08]
	assign err_fatal[`HLE_BIT_INT_PAR] = 1'b0; // [R09]
	assign err_fatal[`HLE_BIT_ILLEGAL] = 1'b1; // [R10]
	assign err_fatal[`HLE_BIT_ADDR_PAR] = 1'b1; // [R11]

	hle_err_t err_seen;
	logic first_empty;
	hle_err_t set_first;
	hle_err_t set_next;
	logic any_fatal;
	logic any_nonfatal;
	hle_glb_t glb_event;
	hle_glb_t set_gfirst;
	hle_glb_t set_gnext;

	// Masked events are dropped before any logging or reporting.
	assign err_seen = hub_link_err_event & ~hub_link_error_suppress; // [R13]
	assign first_empty = (hub_link_first_error_log == `HLE_RST_ERR);
	// The whole same-cycle group lands in the first log together.
	assign set_first = first_empty ? err_seen : `HLE_RST_ERR; // [R01] [R03]
	// Once a first bit is held, further events only reach the next log.
	assign set_next = first_empty ? `HLE_RST_ERR : err_seen; // [R02] [R12]
	assign any_fatal = |(err_seen & err_fatal); // [R18]
	assign any_nonfatal = |(err_seen & ~err_fatal); // [R18]
	assign glb_event = {any_fatal, any_nonfatal};
	assign set_gfirst = glb_event & ~global_earliest_error_log; // [R19]
	assign set_gnext = glb_event & global_earliest_error_log; // [R19]

	// Set wins over a clear that lands in the same cycle.
	hle_err_t next_first;
	hle_err_t next_nerr;
	hle_glb_t next_gfirst;
	hle_glb_t next_gnext;
	assign next_first = w1c(hub_link_first_error_log, wr_err,
		wr_done & hit_first) | set_first; // [R04]
	assign next_nerr = w1c(hub_link_next_error_log, wr_err,
		wr_done & hit_next) | set_next; // [R04]
	assign next_gfirst = (global_earliest_error_log &
		~(wr_done & hit_gfirst ? wr_glb : `HLE_RST_GLB)) | set_gfirst;
	assign next_gnext = (global_later_error_log &
		~(wr_done & hit_gnext ? wr_glb : `HLE_RST_GLB)) | set_gnext; // [R17]

	// Bits that turn from zero to one in either log this cycle.
	hle_err_t new_bits;
	assign new_bits = (next_first & ~hub_link_first_error_log) |
		(next_nerr & ~hub_link_next_error_log);

	// ==========================================================
	// Sticky state, reset only at power-on.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			hub_link_first_error_log <= `HLE_RST_ERR;
			hub_link_next_error_log <= `HLE_RST_ERR;
			hub_link_error_suppress <= `HLE_RST_ERR;
			global_earliest_error_log <= `HLE_RST_GLB;
			global_later_error_log <= `HLE_RST_GLB;
		end else begin
			hub_link_first_error_log <= next_first; // [R01]
			hub_link_next_error_log <= next_nerr; // [R12]
			global_earliest_error_log <= next_gfirst; // [R19]
			global_later_error_log <= next_gnext; // [R17]
			if (wr_done && hit_supp) begin
				hub_link_error_suppress <= wr_err; // [R14]
			end
		end
	end

	// ==========================================================
	// Message enables and message requests.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hub_link_ctrl_irq_enable <= `HLE_RST_ERR;
			hub_link_mgmt_irq_enable <= `HLE_RST_ERR;
			control_interrupt_message <= 1'b0;
			management_interrupt_message <= 1'b0;
		end else begin
			if (wr_done && hit_ctrl) begin
				hub_link_ctrl_irq_enable <= wr_err;
			end
			if (wr_done && hit_mgmt) begin
				hub_link_mgmt_irq_enable <= wr_err;
			end
			// Both enables are honoured; keeping them exclusive is software's job.
			control_interrupt_message <=
				|(new_bits & hub_link_ctrl_irq_enable); // [R15] [R20] [R16]
			management_interrupt_message <=
				|(new_bits & hub_link_mgmt_irq_enable); // [R20]
		end
	end

	// ==========================================================
	// APB slave with one wait state so that every output is a flop.
	logic [31:0] rd_mux;
	logic [31:0] glb_first_word;
	logic [31:0] glb_next_word;

	always_comb begin
		glb_first_word = `HLE_RST_WORD;
		glb_first_word[`HLE_GLB_FATAL_BIT] = global_earliest_error_log[1];
		glb_first_word[`HLE_GLB_NONFATAL_BIT] = global_earliest_error_log[0];
		glb_next_word = `HLE_RST_WORD;
		glb_next_word[`HLE_GLB_FATAL_BIT] = global_later_error_log[1];
		glb_next_word[`HLE_GLB_NONFATAL_BIT] = global_later_error_log[0];
	end

	assign rd_mux =
		hit_first ? {25'h0, hub_link_first_error_log} :
		hit_next ? {25'h0, hub_link_next_error_log} :
		hit_supp ? {25'h0, hub_link_error_suppress} :
		hit_ctrl ? {25'h0, hub_link_ctrl_irq_enable} :
		hit_mgmt ? {25'h0, hub_link_mgmt_irq_enable} :
		hit_gfirst ? glb_first_word :
		hit_gnext ? glb_next_word : `HLE_RST_WORD;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `HLE_RST_WORD;
		end else begin
			pready <= apb_access & ~pready;
			pslverr <= apb_access & ~pready & ~hit_any;
			if (apb_access && !pready && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// ==========================================================
	// Check helpers. They rebuild the rising log bits from stored copies,
	// so the message checks do not lean on the message logic itself.
	hle_err_t chk_first_q;
	hle_err_t chk_nerr_q;
	hle_err_t chk_ctrl_q;
	hle_err_t chk_mgmt_q;
	hle_err_t chk_rise;
	logic chk_live_q;

	always_ff @(posedge pclk) begin
		chk_first_q <= hub_link_first_error_log;
		chk_nerr_q <= hub_link_next_error_log;
		chk_ctrl_q <= hub_link_ctrl_irq_enable;
		chk_mgmt_q <= hub_link_mgmt_irq_enable;
		chk_live_q <= presetn;
	end

	assign chk_rise = (hub_link_first_error_log & ~chk_first_q) |
		(hub_link_next_error_log & ~chk_nerr_q);

	// ==========================================================
	// Checks.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !por_n);

	sequence s_first_held;
		hub_link_first_error_log != `HLE_RST_ERR && !(wr_done && hit_first);
	endsequence

	sequence s_first_wr;
		wr_done && hit_first && err_seen == `HLE_RST_ERR;
	endsequence

	property p_first_frozen;
		s_first_held |=> hub_link_first_error_log ==
			$past(hub_link_first_error_log);
	endproperty
	a_first_frozen: assert property (p_first_frozen) // [R02]
		else $error("First log changed while held.");

	property p_later_to_next;
		(!first_empty && err_seen != `HLE_RST_ERR) |=>
			(hub_link_next_error_log & $past(err_seen)) == $past(err_seen);
	endproperty
	a_later_to_next: assert property (p_later_to_next) // [R01]
		else $error("Later error missing from next log.");

	property p_group_latched;
		(first_empty && err_seen != `HLE_RST_ERR) |=>
			hub_link_first_error_log == $past(err_seen);
	endproperty
	a_group_latched: assert property (p_group_latched) // [R03]
		else $error("Same-cycle first errors not latched together.");

	property p_masked_quiet;
		(first_empty && (hub_link_err_event & ~hub_link_error_suppress) ==
			`HLE_RST_ERR) |=> first_empty;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) // [R13]
		else $error("Masked or absent error reached the first log.");

	property p_w1c_first;
		s_first_wr |=> (hub_link_first_error_log &
			$past(pwdata[`HLE_ERR_MSB:0])) == `HLE_RST_ERR;
	endproperty
	a_w1c_first: assert property (p_w1c_first) // [R04]
		else $error("Write of one did not clear the first log.");

	property p_ctrl_msg;
		(chk_live_q && |(chk_rise & chk_ctrl_q)) |->
			control_interrupt_message;
	endproperty
	a_ctrl_msg: assert property (p_ctrl_msg) // [R15]
		else $error("Enabled new error sent no control message.");

	property p_ctrl_quiet;
		(chk_live_q && !(|(chk_rise & chk_ctrl_q))) |->
			!control_interrupt_message;
	endproperty
	a_ctrl_quiet: assert property (p_ctrl_quiet) // [R20]
		else $error("Control message without a new enabled error.");

	property p_glb_fatal;
		any_fatal |=> (global_earliest_error_log[1] ||
			global_later_error_log[1]);
	endproperty
	a_glb_fatal: assert property (p_glb_fatal) // [R18]
		else $error("Fatal error not seen in global bit 25.");

	property p_glb_second;
		(global_earliest_error_log[0] && any_nonfatal &&
			!(wr_done && hit_gfirst)) |=> global_later_error_log[0];
	endproperty
	a_glb_second: assert property (p_glb_second) // [R19]
		else $error("Second non-fatal error missing from global next.");

	property p_mgmt_msg;
		(chk_live_q && |(chk_rise & chk_mgmt_q)) |->
			management_interrupt_message;
	endproperty
	a_mgmt_msg: assert property (p_mgmt_msg) // [R20]
		else $error("Enabled new error sent no management message.");

	property p_mgmt_quiet;
		(chk_live_q && !(|(chk_rise & chk_mgmt_q))) |->
			!management_interrupt_message;
	endproperty
	a_mgmt_quiet: assert property (p_mgmt_quiet) // [R20]
		else $error("Management message without a new enabled error.");

	property p_mask_kept;
		disable iff (!por_n)
		!(wr_done && hit_supp) |=> $stable(hub_link_error_suppress);
	endproperty
	a_mask_kept: assert property (p_mask_kept) // [R14]
		else $error("Mask changed without a write.");

	property p_first_sticky;
		disable iff (!por_n)
		!(wr_done && hit_first) |=> (hub_link_first_error_log &
			$past(hub_link_first_error_log)) ==
			$past(hub_link_first_error_log);
	endproperty
	a_first_sticky: assert property (p_first_sticky) // [R04]
		else $error("First log bit lost without a write.");

	property p_gnext_sticky;
		disable iff (!por_n)
		!(wr_done && hit_gnext) |=> (global_later_error_log &
			$past(global_later_error_log)) == $past(global_later_error_log);
	endproperty
	a_gnext_sticky: assert property (p_gnext_sticky) // [R17]
		else $error("Global next bit lost without a write.");

	property p_next_cause;
		disable iff (!por_n)
		$past(por_n) |-> (hub_link_next_error_log &
			~$past(hub_link_next_error_log) & ~$past(err_seen)) ==
			`HLE_RST_ERR;
	endproperty
	a_next_cause: assert property (p_next_cause) // [R13]
		else $error("Next log bit set without an unmasked error.");

	property p_glb_nonfatal;
		any_nonfatal |=> (global_earliest_error_log[0] ||
			global_later_error_log[0]);
	endproperty
	a_glb_nonfatal: assert property (p_glb_nonfatal) // [R18]
		else $error("Non-fatal error not seen in global bit 11.");

endmodule

`default_nettype wire

//--- rtl/hle_defs.svh
`ifndef HLE_DEFS_SVH
`define HLE_DEFS_SVH

// ==========================================================
// Register indices; the byte address is four times the index.
`define HLE_IDX_FIRST 10'h050
`define HLE_IDX_NEXT 10'h052
`define HLE_IDX_SUPPRESS 10'h054
`define HLE_IDX_CTRL_EN 10'h058
`define HLE_IDX_MGMT_EN 10'h05a
`define HLE_IDX_GLB_FIRST 10'h040
`define HLE_IDX_GLB_NEXT 10'h044

// ==========================================================
// Error bit positions inside the unit logs.
`define HLE_BIT_TGT_ABORT 6
`define HLE_BIT_ENH_CFG 5
`define HLE_BIT_DATA_PAR 4
`define HLE_BIT_RANGE 3
`define HLE_BIT_INT_PAR 2
`define HLE_BIT_ILLEGAL 1
`define HLE_BIT_ADDR_PAR 0
`define HLE_ERR_MSB 6

// ==========================================================
// Global log bit positions and reset values.
`define HLE_GLB_FATAL_BIT 25
`define HLE_GLB_NONFATAL_BIT 11
`define HLE_RST_BYTE 8'h00
`define HLE_RST_ERR 7'h00
`define HLE_RST_GLB 2'h0
`define HLE_RST_WORD 32'h0000_0000

`endif

//--- rtl/hle_pkg.sv
`include "hle_defs.svh"

package hle_pkg;
	typedef logic [7:0] hle_byte_t;
	typedef logic [`HLE_ERR_MSB:0] hle_err_t;
	typedef logic [1:0] hle_glb_t;
endpackage

//--- test/hle_hub_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far side of the link: raises error pulses, counts message requests.
module hle_hub_model
	import hle_pkg::*;
(
	input wire logic pclk,
	output var hle_err_t hub_link_err_event,
	input wire logic control_interrupt_message,
	input wire logic management_interrupt_message
);
	int n_ctrl = 0;
	int n_mgmt = 0;

	initial hub_link_err_event = '0;

	always @(posedge pclk) begin
		if (control_interrupt_message === 1'b1)
			n_ctrl++;
		if (management_interrupt_message === 1'b1)
			n_mgmt++;
	end

	// Sources flag one cycle only, so a held level would log twice.
	task automatic fire(input hle_err_t ev);
		@(posedge pclk);
		hub_link_err_event <= ev;
		@(posedge pclk);
		hub_link_err_event <= '0;
		repeat (2) @(posedge pclk);
	endtask
endmodule

`default_nettype wire

//--- test/hub_link_error_logging_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hle_defs.svh"

// ==========================================================
// Bench top.
module hub_link_error_logging_tb_top;
	import hle_pkg::*;
	localparam hle_err_t FATAL = 7'h2b;
	localparam hle_err_t CTRL = 7'h2a;
	localparam hle_err_t MGMT = 7'h55;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ctrl_msg;
	logic mgmt_msg;
	hle_err_t ev;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int n_checks = 0;
	int c0;
	int m0;

	always #5 pclk = ~pclk;

	hle_error_log hle_error_log_i (
		.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hub_link_err_event(ev),
		.control_interrupt_message(ctrl_msg),
		.management_interrupt_message(mgmt_msg)
	);

	hle_hub_model hle_hub_model_i (
		.pclk(pclk), .hub_link_err_event(ev),
		.control_interrupt_message(ctrl_msg),
		.management_interrupt_message(mgmt_msg)
	);

	// ==========================================================
	// Checking and bus tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [9:0] idx,
			input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			failures++;
			test_done();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(rd, exp);
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		rd_chk(`HLE_IDX_FIRST, 32'h0);
		rd_chk(`HLE_IDX_NEXT, 32'h0);
		rd_chk(`HLE_IDX_SUPPRESS, 32'h0);
		rd_chk(`HLE_IDX_CTRL_EN, 32'h0);
		rd_chk(`HLE_IDX_GLB_NEXT, 32'h0);
		apb(1'b0, 10'h3ff, 32'h0);
		check(32'(err), 32'h1);
		$display("test reset done");
		// Disjoint enables: one message type per error.
		apb(1'b1, `HLE_IDX_CTRL_EN, 32'(CTRL));
		apb(1'b1, `HLE_IDX_MGMT_EN, 32'(MGMT));
		rd_chk(`HLE_IDX_MGMT_EN, 32'(MGMT));
		for (int i = 0; i < 7; i++) begin
			c0 = hle_hub_model_i.n_ctrl;
			m0 = hle_hub_model_i.n_mgmt;
			hle_hub_model_i.fire(hle_err_t'(1 << i));
			rd_chk(`HLE_IDX_FIRST, 32'(1) << i);
			rd_chk(`HLE_IDX_GLB_FIRST, FATAL[i] ? 32'h0200_0000 : 32'h800);
			check(32'(hle_hub_model_i.n_ctrl - c0), 32'(CTRL[i]));
			check(32'(hle_hub_model_i.n_mgmt - m0), 32'(MGMT[i]));
			apb(1'b1, `HLE_IDX_FIRST, 32'h7f);
			rd_chk(`HLE_IDX_FIRST, 32'h0);
			apb(1'b1, `HLE_IDX_GLB_FIRST, 32'hffff_ffff);
		end
		$display("test single events done");
		hle_hub_model_i.fire(7'h28);
		rd_chk(`HLE_IDX_FIRST, 32'h28);
		hle_hub_model_i.fire(7'h41);
		rd_chk(`HLE_IDX_FIRST, 32'h28);
		rd_chk(`HLE_IDX_NEXT, 32'h41);
		rd_chk(`HLE_IDX_GLB_FIRST, 32'h0200_0800);
		rd_chk(`HLE_IDX_GLB_NEXT, 32'h0200_0000);
		apb(1'b1, `HLE_IDX_FIRST, 32'h0);
		rd_chk(`HLE_IDX_FIRST, 32'h28);
		apb(1'b1, `HLE_IDX_FIRST, 32'h08);
		rd_chk(`HLE_IDX_FIRST, 32'h20);
		$display("test first and next done");
		apb(1'b1, `HLE_IDX_SUPPRESS, 32'h02);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`HLE_IDX_NEXT, 32'h41);
		rd_chk(`HLE_IDX_SUPPRESS, 32'h02);
		apb(1'b1, `HLE_IDX_CTRL_EN, 32'h7f);
		apb(1'b1, `HLE_IDX_FIRST, 32'h7f);
		apb(1'b1, `HLE_IDX_GLB_FIRST, 32'hffff_ffff);
		c0 = hle_hub_model_i.n_ctrl;
		hle_hub_model_i.fire(7'h02);
		rd_chk(`HLE_IDX_FIRST, 32'h0);
		rd_chk(`HLE_IDX_GLB_FIRST, 32'h0);
		check(32'(hle_hub_model_i.n_ctrl - c0), 32'h0);
		hle_hub_model_i.fire(7'h03);
		rd_chk(`HLE_IDX_FIRST, 32'h01);
		check(32'(hle_hub_model_i.n_ctrl - c0), 32'h1);
		$display("test mask and sticky done");
		test_done();
	end
endmodule

`default_nettype wire
